/* File: rtl/safe_stop_map.svh */
/*
  Constants for the safe stop monitor: timing figures and reset values.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef SAFE_STOP_MAP_SVH
`define SAFE_STOP_MAP_SVH

// Core clock rate in kHz
`define CORE_CLK_KHZ        20000
// Longest response time in ms
`define MAX_RESPONSE_MS     8
// Longest response in cycles, exact product of ms and kHz
`define MAX_RESPONSE_CYCLES (`MAX_RESPONSE_MS * `CORE_CLK_KHZ)
// Input agreement filter in cycles, well inside the response bound
`define FILTER_CYCLES       16
// Synchroniser depth
`define SYNC_STAGES         3
// Start-up hold in cycles, one past the synchroniser depth
`define STARTUP_CYCLES      (`SYNC_STAGES + 1)
// Reset values
`define RST_POWER_CUT       1'b1
`define RST_MONITOR         1'b0
`define RST_FAULT           1'b0
`define RST_STOP_LEVEL      1'b0

`endif

/* File: rtl/safe_stop_pkg.sv */
/*
  Types for the safe stop monitor.
  Assumes the map header sits beside it in rtl/.
*/
`include "safe_stop_map.svh"

package safe_stop_pkg;

  typedef enum logic [1:0] {
    ST_CUT,
    ST_RUN,
    ST_FAULT
  } stop_state_t;

  typedef struct packed {
    logic chan_a;
    logic chan_b;
  } stop_pair_t;

endpackage : safe_stop_pkg

/* File: rtl/stop_input_sync.sv */
/*
  Pin synchroniser for one stop channel with agreement of the last two stages.
  Assumes an asynchronous pin input and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "safe_stop_map.svh"

module stop_input_sync #(
  parameter int STAGES = `SYNC_STAGES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Pin and result
  input  wire logic pin_in,
  output var  logic level_out
);

  logic [STAGES-1:0] sync_reg;
  logic [STAGES-1:0] sync_next;
  logic              level_reg;
  logic              level_next;

  // Released is the safe value at reset
  always_comb begin
    sync_next  = {sync_reg[STAGES-2:0], pin_in};
    level_next = level_reg;
    if (sync_reg[STAGES-1] == sync_reg[STAGES-2]) begin
      level_next = sync_reg[STAGES-1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg  <= {STAGES{`RST_STOP_LEVEL}};
      level_reg <= `RST_STOP_LEVEL;
    end else begin
      sync_reg  <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule : stop_input_sync

`default_nettype wire

/* File: rtl/safe_stop_monitor.sv */
/*
  Hard-wired safety stop logic: two redundant stop inputs drive the power cut
  and the external monitor output. Every output comes straight from a
  flip-flop, and the monitor stays off until the synchronisers have filled
  after reset.
  Assumes pins high while current flows (asserted), low when released, and a
  20 MHz core clock with active-low asynchronous reset.
*/
// Summary of operation
// - Either stop input released puts the drive into power cut.
// - Power runs only while the stop inputs carry current.
// - Power cut is complete within 8 ms after both inputs release.
// - Monitor on when both inputs released and power cut is in effect.
// - Monitor off whenever either channel is not working as required.
// - Monitor follows any input change within 8 ms.
`timescale 1ns/1ps
`default_nettype none
`include "safe_stop_map.svh"

module safe_stop_monitor
  import safe_stop_pkg::*;
#(
  parameter int FILTER = `FILTER_CYCLES,
  parameter int MAX_RESPONSE = `MAX_RESPONSE_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Stop inputs, high while current flows
  input  wire logic safe_stop_input_a,
  input  wire logic safe_stop_input_b,
  // Power stage control, high cuts motor power
  output var  logic hardwired_power_cut,
  // External device monitor
  output var  logic stop_state_monitor_out,
  // Channel disagreement held past the allowed time
  output var  logic channel_fault
);

  // Counter widths and channel count
  localparam int CNT_W        = $clog2(MAX_RESPONSE + 1);
  localparam int CHANNELS     = 2;
  localparam int START_CYCLES = `STARTUP_CYCLES;
  localparam int START_W      = $clog2(START_CYCLES + 1);

  // Pin and synchronised channel pairs
  stop_pair_t               pin_pair;
  stop_pair_t               sync_pair;
  wire logic [CHANNELS-1:0] sync_bits;
  // Disagreement timer
  logic [CNT_W-1:0]         mismatch_reg;
  logic [CNT_W-1:0]         mismatch_next;
  // Start-up hold
  logic [START_W-1:0]       start_reg;
  logic [START_W-1:0]       start_next;
  logic                     ready;
  // Channel state
  stop_state_t              state_reg;
  stop_state_t              state_next;
  // Registered outputs
  logic                     fault_reg;
  logic                     fault_next;
  logic                     cut_reg;
  logic                     cut_next;
  logic                     mon_reg;
  logic                     mon_next;

  // Both channels carrying current
  function automatic logic pair_closed(input stop_pair_t pair);
    return pair.chan_a && pair.chan_b;
  endfunction : pair_closed

  // Both channels released
  function automatic logic pair_open(input stop_pair_t pair);
    return !pair.chan_a && !pair.chan_b;
  endfunction : pair_open

  // Channels disagree
  function automatic logic pair_split(input stop_pair_t pair);
    return pair.chan_a != pair.chan_b;
  endfunction : pair_split

  assign pin_pair.chan_a = safe_stop_input_a;
  assign pin_pair.chan_b = safe_stop_input_b;

  // One synchroniser per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_sync
    stop_input_sync #(
      .STAGES(`SYNC_STAGES)
    ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (pin_pair[ch]),
      .level_out(sync_bits[ch])
    );
  end

  assign sync_pair = stop_pair_t'(sync_bits);

  // Start-up hold: the synchronisers show released until the pins arrive
  always_comb begin
    start_next = start_reg;
    if (!ready) begin
      start_next = start_reg + START_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= '0;
    end else begin
      start_reg <= start_next;
    end
  end

  assign ready = (start_reg == START_W'(START_CYCLES));

  // Disagreement timer: a single released channel still cuts power at once,
  // but a lasting split is flagged so the monitor stays off.
  always_comb begin
    mismatch_next = '0;
    if (pair_split(sync_pair)) begin
      mismatch_next = mismatch_reg;
      if (mismatch_reg < CNT_W'(FILTER)) begin
        mismatch_next = mismatch_reg + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_reg <= '0;
    end else begin
      mismatch_reg <= mismatch_next;
    end
  end

  // Channel state: any release cuts power, a lasting split is a fault
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CUT: begin
        if (pair_closed(sync_pair)) begin
          state_next = ST_RUN;
        end else if (mismatch_reg >= CNT_W'(FILTER)) begin
          state_next = ST_FAULT;
        end
      end
      ST_RUN: begin
        if (!pair_closed(sync_pair)) begin
          state_next = ST_CUT;
        end
      end
      ST_FAULT: begin
        // Leave only once both channels agree again
        if (!pair_split(sync_pair)) begin
          state_next = ST_CUT;
        end
      end
      default: begin
        state_next = ST_CUT;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Fault flag follows the next state
  always_comb begin
    fault_next = (state_next == ST_FAULT);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= `RST_FAULT;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // Power cut everywhere but in run
  always_comb begin
    cut_next = (state_next != ST_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cut_reg <= `RST_POWER_CUT;
    end else begin
      cut_reg <= cut_next;
    end
  end

  // Monitor on only in plain cut with both channels released
  always_comb begin
    // Held off until the pins have reached the last stage
    mon_next = ready && cut_next
               && (state_next == ST_CUT)
               && pair_open(sync_pair);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_reg <= `RST_MONITOR;
    end else begin
      mon_reg <= mon_next;
    end
  end

  // Outputs straight from their flip-flops
  assign hardwired_power_cut    = cut_reg;
  assign stop_state_monitor_out = mon_reg;
  assign channel_fault          = fault_reg;

endmodule : safe_stop_monitor

`default_nettype wire

/* File: dv/safe_stop_properties.sv */
/* Port checker for safe_stop_monitor. Assumes the bind below. */
`timescale 1ns/1ps
`default_nettype none
module safe_stop_properties #(
  parameter int FILTER       = 16,
  parameter int MAX_RESPONSE = 160000
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Stop inputs
  input wire logic safe_stop_input_a,
  input wire logic safe_stop_input_b,
  // Design outputs
  input wire logic hardwired_power_cut,
  input wire logic stop_state_monitor_out,
  input wire logic channel_fault
);
  wire a = safe_stop_input_a, b = safe_stop_input_b;
  wire cut = hardwired_power_cut, mon = stop_state_monitor_out;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  cut_on_open_a: assert property ((!a || !b)[*8] |-> cut) else $error("no cut");
  run_closed_a: assert property ((a && b)[*8] |-> ##[0:8] !cut) else $error("no run");
  cut_timely_a: assert property ($fell(b) && !a |-> ##[1:16] cut && mon)
    else $error("cut late");
  mon_in_cut_a: assert property (mon |-> cut && !channel_fault) else $error("mon");
  mon_off_a: assert property ((a || b)[*8] |-> !mon) else $error("mon on");
  mon_follows_a: assert property ($rose(a) |-> ##[1:8] !mon) else $error("mon late");
  sync_cut_a: assert property ($fell(a) && !cut |=> !cut) else $error("cut early");
  mon_start_off_a: assert property ($rose(rst_n) |-> (!mon)[*4]) else $error("mon at start");
endmodule : safe_stop_properties
bind safe_stop_monitor safe_stop_properties #(.FILTER(FILTER), .MAX_RESPONSE(MAX_RESPONSE))
  i_props (.*);
`default_nettype wire

/* File: dv/stop_relay_model.sv */
/* Relay model, B lags A and may stick closed. Needs the package. */
`timescale 1ns/1ps
`default_nettype none
module stop_relay_model import safe_stop_pkg::*; (
  input wire logic core_clk,
  input wire logic stop_req,
  input wire logic stuck_b,
  output var stop_pair_t pins
);
  initial pins = '0;
  always @(negedge core_clk) begin
    pins.chan_a <= !stop_req;
    pins.chan_b <= stuck_b | pins.chan_a;
  end
endmodule : stop_relay_model
`default_nettype wire

/* File: dv/safe_stop_monitor_test.sv */
/* Bench for safe_stop_monitor. Assumes the relay model and checker. */
`timescale 1ns/1ps
`default_nettype none
module safe_stop_monitor_test;
  logic core_clk = 0, rst_n = 0, stop_req = 1, stuck_b = 0, cut, mon, flt;
  int fail_count = 0, checks_done = 0;
  safe_stop_pkg::stop_pair_t pins;
  initial forever #25 core_clk = ~core_clk;
  stop_relay_model i_stop_relay_model (.core_clk, .stop_req, .stuck_b, .pins);
  safe_stop_monitor i_safe_stop_monitor (.core_clk, .rst_n, .safe_stop_input_a(pins.chan_a),
    .safe_stop_input_b(pins.chan_b), .hardwired_power_cut(cut),
    .stop_state_monitor_out(mon), .channel_fault(flt));
  task check(string name, logic seen, logic exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %b seen %b", name, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("errors %0d checks %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task settle(logic c);
    int n;
    for (n = 0; n < 40 && cut !== c; n++) @(negedge core_clk);
    check("cut", cut, c);
    if (n == 40) stop_test;
    repeat (3) @(negedge core_clk);
  endtask : settle
  task open_case;
    stop_req = 1;
    settle(1);
    check("mon", mon, 1);
  endtask : open_case
  task close_case;
    stop_req = 0;
    settle(0);
    check("mon", mon, 0);
  endtask : close_case
  task stuck_case;
    stuck_b = 1;
    close_case;
    stop_req = 1;
    settle(1);
    repeat (30) @(negedge core_clk);
    check("mon", mon, 0);
    check("flt", flt, 1);
    stuck_b = 0;
    repeat (30) @(negedge core_clk);
    check("mon", mon, 1);
    check("flt", flt, 0);
  endtask : stuck_case
  initial begin
    repeat (16) @(negedge core_clk);
    check("cut", cut, 1);
    rst_n = 1;
    @(negedge core_clk);
    check("mon", mon, 0);
    repeat (8) @(negedge core_clk);
    open_case;
    close_case;
    open_case;
    stuck_case;
    close_case;
    stop_test;
  end
endmodule : safe_stop_monitor_test
`default_nettype wire
